// ===== lin_ctrl_pkg.sv
package lin_ctrl_pkg;
	typedef enum logic [2:0] {
		MODE_POR,
		MODE_READY,
		MODE_OPERATION,
		MODE_TRANSMITTER_OFF,
		MODE_POWER_DOWN
	} mode_type;

	localparam int CLK_PERIOD_NS   = 4;
	localparam int CS_FILTER_US    = 10;
	localparam int TXD_TIMEOUT_MS  = 25;
	localparam int BUS_TIMEOUT_MS  = 25;
	localparam int WAKE_LOW_US     = 70;
	// least times round up, longest times round down
	localparam int CS_FILTER_CYC   = (CS_FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TXD_TIMEOUT_CYC = TXD_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int WAKE_LOW_CYC    = (WAKE_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CS_CNT_W        = 12;
	localparam int TO_CNT_W        = 23;
	localparam int WAKE_CNT_W      = 15;

	localparam int LOG_W           = 8;
	localparam int LOG_DEPTH       = 16;
	localparam int LOG_PTR_W       = 4;
	localparam int LOG_MODE_LSB    = 5;
	localparam int LOG_BUS_BIT     = 4;
	localparam int LOG_FLT_LSB     = 0;
endpackage

// ===== lin_host_model.sv
`timescale 1ns/1ps
module lin_host_model (
	input  wire logic clk_i,
	input  wire logic txd_cmd_i,
	input  wire logic cs_cmd_i,
	input  wire logic cs_release_i,
	input  wire logic wake_cmd_i,
	input  wire logic pullup_on_i,
	input  wire logic ext_dom_i,
	input  wire logic bus_line_oe_i,
	input  wire logic rx_oe_i,
	output logic      txd_o,
	output logic      cs_level_o,
	output logic      cs_drive_o,
	output logic      wake_n_o,
	output logic      bus_line_o,
	output logic      rx_pin_o
);
	// floating nodes change every cycle, never a stable last value
	logic float_pat_reg = 1'b0;

	always_ff @(posedge clk_i) begin
		float_pat_reg <= !float_pat_reg;
	end

	assign txd_o      = txd_cmd_i;
	assign cs_drive_o = !cs_release_i;
	assign cs_level_o = cs_release_i ? float_pat_reg : cs_cmd_i;
	assign wake_n_o   = wake_cmd_i;
	// wired bus with pull-up, either side may pull dominant
	assign bus_line_o = !(bus_line_oe_i | ext_dom_i);
	// without pull-up the open receive pin senses low
	assign rx_pin_o   = rx_oe_i ? 1'b0 : pullup_on_i;
endmodule

// ===== lin_log_fifo.sv
`timescale 1ns/1ps
module lin_log_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic         en_i,
	input  wire logic [W-1:0] in_data_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	output logic [W-1:0]      out_data_o,
	output logic              out_valid_o,
	input  wire logic         out_ready_i
);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wr;
		logic [AW-1:0]           rd;
		logic [AW:0]             cnt;
	} fifo_type;

	fifo_type st_reg;
	fifo_type st_next;
	logic     push;
	logic     pop;

	assign in_ready_o  = st_reg.cnt != (AW+1)'(DEPTH);
	assign out_valid_o = st_reg.cnt != '0;
	assign out_data_o  = st_reg.mem[st_reg.rd];

	always_comb begin
		st_next = st_reg;
		push = in_valid_i && in_ready_o;
		pop = out_valid_o && out_ready_i;
		if (push) begin
			st_next.mem[st_reg.wr] = in_data_i;
			st_next.wr = st_reg.wr + 1'b1;
		end
		if (pop) begin
			st_next.rd = st_reg.rd + 1'b1;
		end
		if (push && !pop) begin
			st_next.cnt = st_reg.cnt + 1'b1;
		end else if (pop && !push) begin
			st_next.cnt = st_reg.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_reg <= '0;
		end else if (en_i) begin
			st_reg <= st_next;
		end
	end
endmodule

// ===== lin_transceiver_mode_control.sv
`timescale 1ns/1ps
module lin_transceiver_mode_control
	import lin_ctrl_pkg::*;
#(
	parameter int TXD_TO_CYC = TXD_TIMEOUT_CYC,
	parameter int BUS_TO_CYC = BUS_TIMEOUT_CYC,
	parameter int WAKE_CYC   = WAKE_LOW_CYC
) (
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	input  wire logic         en_i,
	input  wire logic         supply_ok_i,
	input  wire logic         txd_i,
	input  wire logic         cs_level_i,
	input  wire logic         cs_drive_i,
	input  wire logic         wake_n_i,
	input  wire logic         bus_line_i,
	output logic              bus_line_o,
	output logic              bus_line_oe_o,
	input  wire logic         rx_pin_i,
	output logic              rx_o,
	output logic              rx_oe_o,
	output logic              regulator_enable_out_o,
	input  wire logic         thermal_fault_i,
	input  wire logic         contention_fault_i,
	output mode_type          mode_o,
	output logic [LOG_W-1:0]  log_data_o,
	output logic              log_valid_o,
	input  wire logic         log_ready_i,
	output logic              log_ready_o
);
	typedef struct packed {
		mode_type                mode;
		logic                    cs_filt;
		logic [CS_CNT_W-1:0]     cs_cnt;
		logic [TO_CNT_W-1:0]     txd_cnt;
		logic [TO_CNT_W-1:0]     bus_cnt;
		logic [WAKE_CNT_W-1:0]   wake_cnt;
		logic                    txd_prev;
		logic                    bus_prev;
		logic                    wake_prev;
		logic                    txd_flt;
		logic                    bus_flt;
		logic                    rx_flt;
		logic                    bus_oe;
		logic                    rx_oe;
		logic                    ren;
	} ctl_type;

	localparam ctl_type CTL_RESET = '{
		mode:      MODE_POR,
		cs_filt:   1'b0,
		cs_cnt:    '0,
		txd_cnt:   '0,
		bus_cnt:   '0,
		wake_cnt:  '0,
		txd_prev:  1'b1,
		bus_prev:  1'b1,
		wake_prev: 1'b1,
		txd_flt:   1'b0,
		bus_flt:   1'b0,
		rx_flt:    1'b0,
		bus_oe:    1'b0,
		rx_oe:     1'b0,
		ren:       1'b0
	};

	ctl_type            st_reg;
	ctl_type            st_next;
	logic               cs_eff;
	logic               cs_fall;
	logic               wake_fall;
	logic               bus_wake;
	logic               txd_expire;
	logic               bus_expire;
	logic               faults_any;
	logic               tx_en;
	logic               txd_eff;
	logic               log_push;
	logic [LOG_W-1:0]   log_word;

	// saturating count toward a limit
	function automatic logic [TO_CNT_W-1:0] bump(input logic [TO_CNT_W-1:0] cnt,
		input logic [TO_CNT_W-1:0] lim);
		bump = (cnt >= lim) ? lim : cnt + 1'b1;
	endfunction

	always_comb begin
		st_next = st_reg;
		cs_eff = cs_drive_i & cs_level_i;

		// chip-select integrator: flips only after a steady disagreement
		if (cs_eff == st_reg.cs_filt) begin
			st_next.cs_cnt = '0;
		end else if (st_reg.cs_cnt == CS_CNT_W'(CS_FILTER_CYC - 1)) begin
			st_next.cs_filt = cs_eff;
			st_next.cs_cnt = '0;
		end else begin
			st_next.cs_cnt = st_reg.cs_cnt + 1'b1;
		end
		cs_fall = st_reg.cs_filt && !st_next.cs_filt;

		// transmit-dominant timeout
		txd_expire = !txd_i && st_reg.txd_cnt == TO_CNT_W'(TXD_TO_CYC - 1);
		if (txd_i) begin
			st_next.txd_cnt = '0;
		end else begin
			st_next.txd_cnt = bump(st_reg.txd_cnt, TO_CNT_W'(TXD_TO_CYC - 1));
		end
		if (txd_expire) begin
			st_next.txd_flt = 1'b1;
		end else if (txd_i && !st_reg.txd_prev) begin
			st_next.txd_flt = 1'b0;
		end

		// bus-dominant timeout
		bus_expire = !bus_line_i && st_reg.bus_cnt == TO_CNT_W'(BUS_TO_CYC - 1);
		if (bus_line_i) begin
			st_next.bus_cnt = '0;
		end else begin
			st_next.bus_cnt = bump(st_reg.bus_cnt, TO_CNT_W'(BUS_TO_CYC - 1));
		end
		if (bus_expire) begin
			st_next.bus_flt = 1'b1;
		end else if (bus_line_i && st_next.cs_filt) begin
			st_next.bus_flt = 1'b0;
		end

		// receive-pin monitor; a missing pull-up keeps the fault standing
		// receive drive lags the bus one clock: judge only after two recessive samples
		if (st_reg.mode == MODE_OPERATION && st_reg.bus_prev && bus_line_i && !rx_pin_i) begin
			st_next.rx_flt = 1'b1;
		end else if (bus_line_i && rx_pin_i) begin
			st_next.rx_flt = 1'b0;
		end

		// remote wake qualifier
		if (st_reg.mode == MODE_POWER_DOWN && !bus_line_i) begin
			st_next.wake_cnt = WAKE_CNT_W'(bump(TO_CNT_W'(st_reg.wake_cnt),
				TO_CNT_W'(WAKE_CYC)));
		end else begin
			st_next.wake_cnt = '0;
		end
		bus_wake = st_reg.mode == MODE_POWER_DOWN && bus_line_i && !st_reg.bus_prev
			&& st_reg.wake_cnt == WAKE_CNT_W'(WAKE_CYC);
		wake_fall = st_reg.wake_prev && !wake_n_i;

		faults_any = st_next.txd_flt || st_next.bus_flt || st_next.rx_flt
			|| thermal_fault_i || contention_fault_i;

		case (st_reg.mode)
			MODE_POR: begin
				// decide only once supplies are up and the filter has settled
				if (supply_ok_i && cs_eff == st_reg.cs_filt) begin
					if (!st_reg.cs_filt) begin
						st_next.mode = MODE_READY;
					end else if (txd_i && !faults_any) begin
						st_next.mode = MODE_OPERATION;
					end else begin
						st_next.mode = MODE_TRANSMITTER_OFF;
					end
				end
			end
			MODE_READY: begin
				if (st_reg.cs_filt) begin
					st_next.mode = txd_i ? MODE_OPERATION : MODE_TRANSMITTER_OFF;
				end
			end
			MODE_OPERATION: begin
				if (cs_fall && txd_i) begin
					st_next.mode = MODE_POWER_DOWN;
				end else if (faults_any) begin
					st_next.mode = MODE_TRANSMITTER_OFF;
				end
			end
			MODE_TRANSMITTER_OFF: begin
				if (cs_fall) begin
					st_next.mode = MODE_POWER_DOWN;
				end else if (!faults_any && txd_i && st_reg.cs_filt) begin
					st_next.mode = MODE_OPERATION;
				end
			end
			MODE_POWER_DOWN: begin
				if (st_reg.cs_filt || wake_fall || bus_wake) begin
					st_next.mode = MODE_READY;
				end
			end
			default: begin
				st_next.mode = MODE_POR;
			end
		endcase

		tx_en = st_next.mode == MODE_OPERATION && st_next.cs_filt && !faults_any;
		txd_eff = tx_en ? txd_i : 1'b1;
		st_next.bus_oe = !txd_eff;
		st_next.rx_oe = st_next.mode != MODE_POWER_DOWN && !bus_line_i;
		st_next.ren = st_next.mode != MODE_POWER_DOWN;
		st_next.txd_prev = txd_i;
		st_next.bus_prev = bus_line_i;
		st_next.wake_prev = wake_n_i;

		log_push = en_i && st_next.mode != st_reg.mode;
		log_word = '0;
		log_word[LOG_MODE_LSB +: 3] = st_next.mode;
		log_word[LOG_BUS_BIT] = bus_line_i;
		log_word[LOG_FLT_LSB +: 4] = {st_next.txd_flt, st_next.bus_flt, st_next.rx_flt,
			thermal_fault_i | contention_fault_i};
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_reg <= CTL_RESET;
		end else if (en_i) begin
			st_reg <= st_next;
		end
	end

	// open-drain pins: level is always low, enable says drive
	assign bus_line_o             = 1'b0;
	assign bus_line_oe_o          = st_reg.bus_oe;
	assign rx_o                   = 1'b0;
	assign rx_oe_o                = st_reg.rx_oe;
	assign regulator_enable_out_o = st_reg.ren;
	assign mode_o                 = st_reg.mode;

	lin_log_fifo #(
		.W     (LOG_W),
		.DEPTH (LOG_DEPTH),
		.AW    (LOG_PTR_W)
	) u_log_fifo (
		.clk_i       (clk_i),
		.nrst_i      (nrst_i),
		.en_i        (en_i),
		.in_data_i   (log_word),
		.in_valid_i  (log_push),
		.in_ready_o  (log_ready_o),
		.out_data_o  (log_data_o),
		.out_valid_o (log_valid_o),
		.out_ready_i (log_ready_i)
	);

	property p_rx_mirror;
		@(posedge clk_i) disable iff (!nrst_i)
		en_i && st_reg.mode != MODE_POWER_DOWN && st_next.mode != MODE_POWER_DOWN
			|=> rx_oe_o == !$past(bus_line_i);
	endproperty
	a_rx_mirror: assert property (p_rx_mirror) else $error("receive output lost the bus");

	property p_rx_monitor;
		@(posedge clk_i) disable iff (!nrst_i)
		en_i && st_reg.mode == MODE_OPERATION && st_reg.bus_prev && bus_line_i && !rx_pin_i
			&& !(cs_fall && txd_i)
			|=> st_reg.rx_flt && st_reg.mode == MODE_TRANSMITTER_OFF && !bus_line_oe_o;
	endproperty
	a_rx_monitor: assert property (p_rx_monitor) else $error("receive pin fault missed");

	property p_tx_needs_cs;
		@(posedge clk_i) disable iff (!nrst_i)
		bus_line_oe_o |-> st_reg.cs_filt && st_reg.mode == MODE_OPERATION;
	endproperty
	a_tx_needs_cs: assert property (p_tx_needs_cs) else $error("bus driven without select");

	property p_cs_filter;
		@(posedge clk_i) disable iff (!nrst_i)
		en_i && st_reg.cs_filt != cs_eff && st_reg.cs_cnt == '0
			|=> st_reg.cs_filt == $past(st_reg.cs_filt);
	endproperty
	a_cs_filter: assert property (p_cs_filter) else $error("select glitch passed filter");

	property p_tx_forced;
		@(posedge clk_i) disable iff (!nrst_i)
		en_i ##1 bus_line_oe_o |-> !$past(txd_i);
	endproperty
	a_tx_forced: assert property (p_tx_forced) else $error("bus driven with transmit high");

	property p_wake_pin;
		@(posedge clk_i) disable iff (!nrst_i)
		en_i && st_reg.mode == MODE_POWER_DOWN && st_reg.wake_prev && !wake_n_i
			|=> st_reg.mode == MODE_READY;
	endproperty
	a_wake_pin: assert property (p_wake_pin) else $error("wake edge ignored");

	property p_txd_timeout;
		@(posedge clk_i) disable iff (!nrst_i)
		en_i && !txd_i && st_reg.txd_cnt == TO_CNT_W'(TXD_TO_CYC - 1)
			|=> st_reg.txd_flt && !bus_line_oe_o && st_reg.mode != MODE_OPERATION;
	endproperty
	a_txd_timeout: assert property (p_txd_timeout) else $error("transmit timeout missed");

	property p_bus_clear;
		@(posedge clk_i) disable iff (!nrst_i)
		en_i && bus_line_i |=> st_reg.bus_cnt == '0;
	endproperty
	a_bus_clear: assert property (p_bus_clear) else $error("bus timer not cleared");

	property p_regulator;
		@(posedge clk_i) disable iff (!nrst_i)
		en_i && nrst_i |=> regulator_enable_out_o == (st_reg.mode != MODE_POWER_DOWN);
	endproperty
	a_regulator: assert property (p_regulator) else $error("regulator enable wrong");

	property p_op_sleep;
		@(posedge clk_i) disable iff (!nrst_i)
		en_i && st_reg.mode == MODE_OPERATION && cs_fall && txd_i
			|=> st_reg.mode == MODE_POWER_DOWN && !regulator_enable_out_o && !rx_oe_o;
	endproperty
	a_op_sleep: assert property (p_op_sleep) else $error("no power-down on select fall");

	sequence s_ready_select;
		en_i && st_reg.mode == MODE_READY && st_reg.cs_filt;
	endsequence
	sequence s_enter_by_txd;
		st_reg.mode == ($past(txd_i) ? MODE_OPERATION : MODE_TRANSMITTER_OFF);
	endsequence
	property p_ready_exit;
		@(posedge clk_i) disable iff (!nrst_i)
		s_ready_select |=> s_enter_by_txd;
	endproperty
	a_ready_exit: assert property (p_ready_exit) else $error("ready exit wrong");
endmodule

// ===== lin_transceiver_mode_control_bench.sv
`timescale 1ns/1ps
module lin_transceiver_mode_control_bench;
	import lin_ctrl_pkg::*;
	logic clk_i, nrst_i, txd_c, cs_c, cs_rel, wake_c, pull_c, dom_c, therm_c, cont_c, lrdy_c;
	logic en_c, sup_c;
	logic txd, csl, csd, wk, bus, rxp, oe, rxoe, reg_en, lvalid, lready, b, lb;
	logic [LOG_W-1:0] ldata;
	mode_type mode;
	logic [2:0] exp_q[$];
	int mismatches, tests_run, i, n;

	lin_host_model i_lin_host_model (.clk_i(clk_i), .txd_cmd_i(txd_c), .cs_cmd_i(cs_c),
		.cs_release_i(cs_rel), .wake_cmd_i(wake_c), .pullup_on_i(pull_c), .ext_dom_i(dom_c),
		.bus_line_oe_i(oe), .rx_oe_i(rxoe), .txd_o(txd), .cs_level_o(csl), .cs_drive_o(csd),
		.wake_n_o(wk), .bus_line_o(bus), .rx_pin_o(rxp));

	lin_transceiver_mode_control #(.TXD_TO_CYC(64), .BUS_TO_CYC(64), .WAKE_CYC(20))
	i_lin_transceiver_mode_control (.clk_i(clk_i), .nrst_i(nrst_i), .en_i(en_c),
		.supply_ok_i(sup_c), .txd_i(txd), .cs_level_i(csl), .cs_drive_i(csd), .wake_n_i(wk),
		.bus_line_i(bus), .bus_line_o(), .bus_line_oe_o(oe), .rx_pin_i(rxp), .rx_o(),
		.rx_oe_o(rxoe), .regulator_enable_out_o(reg_en), .thermal_fault_i(therm_c),
		.contention_fault_i(cont_c), .mode_o(mode), .log_data_o(ldata),
		.log_valid_o(lvalid), .log_ready_i(lrdy_c), .log_ready_o(lready));

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = !clk_i;
	end

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
		#1;
	endtask

	// bounded wait; every reached mode is one log word while room is left
	task automatic wait_mode(input mode_type m, input int lim);
		int k;
		k = 0;
		while (mode !== m && k < lim) begin
			cyc(1);
			k++;
		end
		chk("mode", 8'(m), 8'(mode));
		if (mode !== m) report_and_stop();
		else if (exp_q.size() < LOG_DEPTH) exp_q.push_back(m);
	endtask

	initial begin
		{nrst_i, txd_c, cs_c, cs_rel, wake_c, pull_c} = 6'b010011;
		{dom_c, therm_c, cont_c, lrdy_c} = 4'h0;
		{en_c, sup_c} = 2'b10;
		void'($urandom(48405));
		cyc(6);
		@(posedge clk_i) nrst_i <= 1'b1;
		cyc(8);
		chk("mode", 8'(MODE_POR), 8'(mode));
		chk("reg_en", 8'h01, 8'(reg_en));
		@(posedge clk_i) sup_c <= 1'b1;
		wait_mode(MODE_READY, 100);
		chk("reg_en", 8'h01, 8'(reg_en));
		chk("oe", 8'h00, 8'(oe));
		@(posedge clk_i) cs_c <= 1'b1;
		cyc(2000);
		chk("mode", 8'(MODE_READY), 8'(mode));
		wait_mode(MODE_OPERATION, 700);
		for (i = 0; i < 40; i++) begin
			b = 1'($urandom_range(1, 0));
			@(posedge clk_i) txd_c <= b;
			cyc(1);
			chk("oe", 8'(!b), 8'(oe));
			lb = bus;
			cyc(1);
			chk("rx_oe", 8'(!lb), 8'(rxoe));
		end
		@(posedge clk_i) txd_c <= 1'b0;
		wait_mode(MODE_TRANSMITTER_OFF, 80);
		cyc(3);
		chk("oe", 8'h00, 8'(oe));
		@(posedge clk_i) txd_c <= 1'b1;
		wait_mode(MODE_OPERATION, 5);
		@(posedge clk_i) dom_c <= 1'b1;
		wait_mode(MODE_TRANSMITTER_OFF, 80);
		@(posedge clk_i) dom_c <= 1'b0;
		wait_mode(MODE_OPERATION, 5);
		@(posedge clk_i) pull_c <= 1'b0;
		wait_mode(MODE_TRANSMITTER_OFF, 5);
		@(posedge clk_i) pull_c <= 1'b1;
		wait_mode(MODE_OPERATION, 5);
		for (i = 1; i < 3; i++) begin
			@(posedge clk_i) {cont_c, therm_c} <= 2'(i);
			wait_mode(MODE_TRANSMITTER_OFF, 5);
			chk("oe", 8'h00, 8'(oe));
			@(posedge clk_i) {cont_c, therm_c} <= 2'b00;
			wait_mode(MODE_OPERATION, 5);
		end
		@(posedge clk_i) cs_rel <= 1'b1;
		wait_mode(MODE_POWER_DOWN, 2600);
		cyc(2);
		chk("reg_en", 8'h00, 8'(reg_en));
		chk("rx_oe", 8'h00, 8'(rxoe));
		@(posedge clk_i) {en_c, wake_c} <= 2'b00;
		cyc(10);
		chk("mode", 8'(MODE_POWER_DOWN), 8'(mode));
		@(posedge clk_i) en_c <= 1'b1;
		wait_mode(MODE_READY, 5);
		@(posedge clk_i) {wake_c, cs_rel} <= 2'b10;
		cyc(500);
		@(posedge clk_i) cs_c <= 1'b0;
		cyc(2600);
		chk("mode", 8'(MODE_READY), 8'(mode));
		@(posedge clk_i) cs_c <= 1'b1;
		wait_mode(MODE_OPERATION, 2700);
		@(posedge clk_i) cs_c <= 1'b0;
		wait_mode(MODE_POWER_DOWN, 2700);
		for (n = 10; n <= 30; n += 20) begin
			@(posedge clk_i) dom_c <= 1'b1;
			cyc(n);
			@(posedge clk_i) dom_c <= 1'b0;
			if (n == 10) cyc(10);
			if (n == 10) chk("mode", 8'(MODE_POWER_DOWN), 8'(mode));
		end
		wait_mode(MODE_READY, 5);
		chk("log_full", 8'h00, 8'(lready));
		for (i = 0; i < LOG_DEPTH; i++) begin
			chk("log_valid", 8'h01, 8'(lvalid));
			chk("log_mode", 8'(exp_q.pop_front()), 8'(ldata[7:5]));
			@(posedge clk_i) lrdy_c <= 1'b1;
			@(posedge clk_i) lrdy_c <= 1'b0;
			cyc(1);
		end
		chk("log_valid", 8'h00, 8'(lvalid));
		@(posedge clk_i) {nrst_i, cs_rel, cs_c} <= 3'b001;
		cyc(6);
		@(posedge clk_i) nrst_i <= 1'b1;
		wait_mode(MODE_OPERATION, 2700);
		@(posedge clk_i) {nrst_i, txd_c} <= 2'b00;
		cyc(6);
		@(posedge clk_i) nrst_i <= 1'b1;
		wait_mode(MODE_TRANSMITTER_OFF, 2700);
		chk("oe", 8'h00, 8'(oe));
		report_and_stop();
	end
endmodule
